// [logic/dac_map.vh]
`ifndef DAC_MAP_VH
`define DAC_MAP_VH
// Divider
`define DAC_DIV_W 3
`define DAC_DIV_RST 3'h0
// Sync control bits of the clock-control word
`define DAC_SYNC_EN_BIT 1
`define DAC_SYNC_ONCE_BIT 2
`define DAC_SYNC_CTL_ADDR 8'h3A
// Output control bit position
`define DAC_OUT_OFF_BIT 4
`define DAC_OUT_CTL_ADDR 8'h14
// Sample format
`define DAC_FMT_OFFBIN 2'h0
`define DAC_FMT_TWOS 2'h1
`define DAC_FMT_GRAY 2'h2
`define DAC_FMT_RST 2'h1
// Power modes
`define DAC_PWR_RUN 2'h0
`define DAC_PWR_DOWN 2'h1
`define DAC_PWR_STBY 2'h2
// Pipeline
`define DAC_LATENCY 10
`define DAC_SAMPLE_W 12
`define DAC_NEG_FS 12'h800
`define DAC_POS_FS 12'h7FF
// Stabilizer timing
`define DAC_CLK_HZ 50000000
`define DAC_RELOCK_MIN_NS 1500
`define DAC_RELOCK_MAX_NS 5000
`define DAC_DCS_MIN_HZ 40000000
`define DAC_LOCK_CNT_W 9
`endif

// [logic/dac_delay_line.v]
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module dac_delay_line #(
  parameter WIDTH = 13,
  parameter DEPTH = `DAC_LATENCY
) (
  input wire core_clk,
  input wire srst,
  input wire adv,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage_reg [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
      always @(posedge core_clk) begin
        if (srst) begin
          stage_reg[i] <= {WIDTH{1'b0}};
        end else if (adv) begin
          if (i == 0) begin
            stage_reg[i] <= din;
          end else begin
            stage_reg[i] <= stage_reg[i-1];
          end
        end
      end
    end
  endgenerate
  assign dout = stage_reg[DEPTH-1];
endmodule // dac_delay_line
`default_nettype wire

// [logic/dac_clock_output_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
// Behaviour
// - Input clock divided by integer ratio 1 to 8 before conversion.
// - Two sync bits choose realign on every or first sync after write.
// - Accepted sync returns divider to its initial count.
// - Stabilizer enabled out of reset without any write.
// - Locked stabilizer makes falling edge at mid period, rising kept.
// - Stabilizer loop treated as dead below 40 MHz rate.
// - Relock takes 1.5 to 5 us after any frequency change.
// - Unlocked stabilizer is bypassed, raw duty cycle passes.
// - Power-down by config bit or pin high; pin low restores.
// - Power-down puts all output drivers in high impedance.
// - Standby mode keeps reference powered, distinct from power-down.
// - Output coding selectable: offset binary, twos complement, Gray.
// - Data drivers enabled with disable pin low, off when high.
// - Output-off bits three-state the data bus only when both channels are off.
// - One channel off: remaining sample repeated on both phases.
// - Samples appear ten sample clocks later after rising edge.
// - Data capture clock driven beside the data.
// - Overrange flag delayed ten clocks, aligned with sample.
// - Twos complement and offset binary full-scale codes as specified.
// - Beyond full scale the code saturates and overrange is set.
// - External sync resynchronised to the sample clock before use.
// - Each sample taken on rising edge of conversion clock.
module dac_clock_output_ctrl (
  input wire core_clk,
  input wire srst,
  input wire [`DAC_DIV_W-1:0] div_ratio_m1,
  input wire sync_pin,
  input wire sync_ctl_wr,
  input wire [7:0] sync_ctl_data,
  input wire stab_cfg_wr,
  input wire stab_cfg_en,
  input wire in_clk_slow,
  input wire freq_change,
  input wire raw_in_clk_level,
  input wire power_off_request,
  input wire [1:0] pwr_mode_cfg,
  input wire output_disable_pin,
  input wire [7:0] out_ctl_a,
  input wire [7:0] out_ctl_b,
  input wire [1:0] fmt_cfg,
  input wire [`DAC_SAMPLE_W:0] ain_a,
  input wire [`DAC_SAMPLE_W:0] ain_b,
  output reg conv_strobe,
  output reg int_clk,
  output reg stab_locked,
  output reg stab_bypass,
  output reg stab_enabled,
  output reg powered_down,
  output reg reference_on,
  output reg [`DAC_SAMPLE_W-1:0] data_out,
  output wire data_out_oe,
  output reg data_capture_clock,
  output wire data_capture_clock_oe,
  output reg overrange,
  output wire overrange_oe
);
  localparam [31:0] RELOCK_MIN_FULL =
    (`DAC_RELOCK_MIN_NS * (`DAC_CLK_HZ / 1000000) + 999) / 1000;
  localparam [31:0] RELOCK_MAX_FULL =
    (`DAC_RELOCK_MAX_NS * (`DAC_CLK_HZ / 1000000)) / 1000;
  localparam [`DAC_LOCK_CNT_W-1:0] RELOCK_MIN_CYC = RELOCK_MIN_FULL[`DAC_LOCK_CNT_W-1:0];
  localparam [`DAC_LOCK_CNT_W-1:0] RELOCK_MAX_CYC = RELOCK_MAX_FULL[`DAC_LOCK_CNT_W-1:0];

  // ---------------------------------------------------------------
  // Sync input resynchroniser
  // ---------------------------------------------------------------
  reg sync_s1_reg;
  reg sync_s2_reg;
  reg sync_s3_reg;
  reg sync_lvl_reg;
  wire sync_rise;
  always @(posedge core_clk) begin
    if (srst) begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
      sync_lvl_reg <= 1'b0;
    end else begin
      sync_s1_reg <= sync_pin;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
      if (sync_s2_reg == sync_s3_reg) begin
        sync_lvl_reg <= sync_s3_reg;
      end
    end
  end
  assign sync_rise = (sync_s2_reg == sync_s3_reg) && sync_s3_reg && !sync_lvl_reg;

  // ---------------------------------------------------------------
  // Sync mode control
  // ---------------------------------------------------------------
  reg sync_en_reg;
  reg sync_once_reg;
  reg once_armed_reg;
  wire sync_accept;
  always @(posedge core_clk) begin
    if (srst) begin
      sync_en_reg <= 1'b0;
      sync_once_reg <= 1'b0;
      once_armed_reg <= 1'b0;
    end else if (sync_ctl_wr) begin
      sync_en_reg <= sync_ctl_data[`DAC_SYNC_EN_BIT];
      sync_once_reg <= sync_ctl_data[`DAC_SYNC_ONCE_BIT];
      once_armed_reg <= 1'b1;
    end else if (sync_rise && sync_once_reg) begin
      once_armed_reg <= 1'b0;
    end
  end
  assign sync_accept = sync_rise && sync_en_reg && (!sync_once_reg || once_armed_reg);

  // ---------------------------------------------------------------
  // Input clock divider
  // ---------------------------------------------------------------
  reg [`DAC_DIV_W-1:0] div_cnt_reg;
  reg [`DAC_DIV_W-1:0] div_ratio_reg;
  reg [`DAC_DIV_W-1:0] div_cnt_next;
  wire div_wrap;
  wire [`DAC_DIV_W-1:0] half_point;
  assign div_wrap = (div_cnt_reg == div_ratio_reg);
  assign half_point = {1'b0, div_ratio_reg[`DAC_DIV_W-1:1]};
  always @* begin
    div_cnt_next = div_cnt_reg + 3'h1;
    if (div_wrap) begin
      div_cnt_next = `DAC_DIV_RST;
    end
    if (sync_accept) begin
      div_cnt_next = `DAC_DIV_RST;
    end
  end
  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt_reg <= `DAC_DIV_RST;
      div_ratio_reg <= `DAC_DIV_RST;
      conv_strobe <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      if (div_wrap || sync_accept) begin
        div_ratio_reg <= div_ratio_m1;
      end
      conv_strobe <= (div_cnt_next == `DAC_DIV_RST) && !powered_down;
    end
  end

  // ---------------------------------------------------------------
  // Duty-cycle stabilizer
  // ---------------------------------------------------------------
  reg [`DAC_LOCK_CNT_W-1:0] lock_cnt_reg;
  reg [`DAC_LOCK_CNT_W-1:0] lock_cnt_next;
  reg stab_enabled_next;
  reg stab_locked_next;
  always @* begin
    stab_enabled_next = stab_enabled;
    stab_locked_next = stab_locked;
    lock_cnt_next = lock_cnt_reg;
    if (stab_cfg_wr) begin
      stab_enabled_next = stab_cfg_en;
    end
    if (!stab_enabled_next || in_clk_slow || freq_change) begin
      stab_locked_next = 1'b0;
      lock_cnt_next = {`DAC_LOCK_CNT_W{1'b0}};
    end else if (!stab_locked) begin
      if (lock_cnt_reg >= RELOCK_MIN_CYC) begin
        stab_locked_next = 1'b1;
      end else begin
        lock_cnt_next = lock_cnt_reg + 9'h001;
      end
    end
  end
  always @(posedge core_clk) begin
    if (srst) begin
      stab_enabled <= 1'b1;
      stab_locked <= 1'b0;
      lock_cnt_reg <= {`DAC_LOCK_CNT_W{1'b0}};
    end else begin
      stab_enabled <= stab_enabled_next;
      stab_locked <= stab_locked_next;
      lock_cnt_reg <= lock_cnt_next;
    end
  end
  always @(posedge core_clk) begin
    if (srst) begin
      stab_bypass <= 1'b1;
      int_clk <= 1'b0;
    end else begin
      stab_bypass <= !(stab_enabled_next && stab_locked_next);
      if (stab_enabled_next && stab_locked_next) begin
        if (div_cnt_next == `DAC_DIV_RST) begin
          int_clk <= 1'b1;
        end else if (div_cnt_next == half_point + 3'h1 || div_ratio_reg == `DAC_DIV_RST) begin
          int_clk <= 1'b0;
        end
      end else begin
        int_clk <= raw_in_clk_level;
      end
    end
  end

  // ---------------------------------------------------------------
  // Power-down pin resynchroniser
  // ---------------------------------------------------------------
  reg pwr_s1_reg;
  reg pwr_s2_reg;
  reg pwr_s3_reg;
  reg pwr_lvl_reg;
  wire pwr_pin_filt;
  always @(posedge core_clk) begin
    if (srst) begin
      pwr_s1_reg <= 1'b0;
      pwr_s2_reg <= 1'b0;
      pwr_s3_reg <= 1'b0;
      pwr_lvl_reg <= 1'b0;
    end else begin
      pwr_s1_reg <= power_off_request;
      pwr_s2_reg <= pwr_s1_reg;
      pwr_s3_reg <= pwr_s2_reg;
      pwr_lvl_reg <= pwr_pin_filt;
    end
  end
  assign pwr_pin_filt = (pwr_s2_reg == pwr_s3_reg) ? pwr_s3_reg : pwr_lvl_reg;

  // ---------------------------------------------------------------
  // Power control
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      powered_down <= 1'b0;
      reference_on <= 1'b1;
    end else begin
      powered_down <= pwr_pin_filt || (pwr_mode_cfg == `DAC_PWR_DOWN) ||
        (pwr_mode_cfg == `DAC_PWR_STBY);
      reference_on <= !(pwr_pin_filt || (pwr_mode_cfg == `DAC_PWR_DOWN));
    end
  end

  // ---------------------------------------------------------------
  // Saturation and coding
  // ---------------------------------------------------------------
  wire a_over;
  wire b_over;
  wire [`DAC_SAMPLE_W-1:0] a_sat;
  wire [`DAC_SAMPLE_W-1:0] b_sat;
  assign a_over = ain_a[`DAC_SAMPLE_W] != ain_a[`DAC_SAMPLE_W-1];
  assign b_over = ain_b[`DAC_SAMPLE_W] != ain_b[`DAC_SAMPLE_W-1];
  assign a_sat = a_over ? (ain_a[`DAC_SAMPLE_W] ? `DAC_NEG_FS : `DAC_POS_FS) :
    ain_a[`DAC_SAMPLE_W-1:0];
  assign b_sat = b_over ? (ain_b[`DAC_SAMPLE_W] ? `DAC_NEG_FS : `DAC_POS_FS) :
    ain_b[`DAC_SAMPLE_W-1:0];

  function [`DAC_SAMPLE_W-1:0] encode;
    input [`DAC_SAMPLE_W-1:0] twos;
    input [1:0] fmt;
    reg [`DAC_SAMPLE_W-1:0] ob;
    begin
      ob = {~twos[`DAC_SAMPLE_W-1], twos[`DAC_SAMPLE_W-2:0]};
      if (fmt == `DAC_FMT_OFFBIN) begin
        encode = ob;
      end else if (fmt == `DAC_FMT_GRAY) begin
        encode = ob ^ {1'b0, ob[`DAC_SAMPLE_W-1:1]};
      end else begin
        encode = twos;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Pipeline latency
  // ---------------------------------------------------------------
  wire [`DAC_SAMPLE_W:0] pipe_a;
  wire [`DAC_SAMPLE_W:0] pipe_b;
  dac_delay_line #(
    .WIDTH(`DAC_SAMPLE_W + 1),
    .DEPTH(`DAC_LATENCY)
  ) u_delay_a (
    .core_clk(core_clk),
    .srst(srst),
    .adv(conv_strobe),
    .din({a_over, encode(a_sat, fmt_cfg)}),
    .dout(pipe_a)
  );
  dac_delay_line #(
    .WIDTH(`DAC_SAMPLE_W + 1),
    .DEPTH(`DAC_LATENCY)
  ) u_delay_b (
    .core_clk(core_clk),
    .srst(srst),
    .adv(conv_strobe),
    .din({b_over, encode(b_sat, fmt_cfg)}),
    .dout(pipe_b)
  );

  // ---------------------------------------------------------------
  // Output interleave and enables
  // ---------------------------------------------------------------
  wire a_off;
  wire b_off;
  wire phase_b;
  reg [`DAC_SAMPLE_W:0] sel;
  assign a_off = out_ctl_a[`DAC_OUT_OFF_BIT];
  assign b_off = out_ctl_b[`DAC_OUT_OFF_BIT];
  assign phase_b = (div_cnt_reg > half_point);
  always @* begin
    if (a_off && !b_off) begin
      sel = pipe_b;
    end else if (b_off && !a_off) begin
      sel = pipe_a;
    end else if (phase_b && div_ratio_reg != `DAC_DIV_RST) begin
      sel = pipe_b;
    end else begin
      sel = pipe_a;
    end
  end
  always @(posedge core_clk) begin
    if (srst) begin
      data_out <= {`DAC_SAMPLE_W{1'b0}};
      overrange <= 1'b0;
      data_capture_clock <= 1'b0;
    end else begin
      data_out <= sel[`DAC_SAMPLE_W-1:0];
      overrange <= sel[`DAC_SAMPLE_W];
      data_capture_clock <= !phase_b;
    end
  end
  assign data_out_oe = !powered_down && !output_disable_pin && !(a_off && b_off);
  assign overrange_oe = data_out_oe;
  assign data_capture_clock_oe = !powered_down;
endmodule // dac_clock_output_ctrl
`default_nettype wire

// [sim/dac_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module dac_ctrl_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_clk_slow,
  input wire logic power_off_request,
  input wire logic [1:0] pwr_mode_cfg,
  input wire logic output_disable_pin,
  input wire logic stab_locked,
  input wire logic stab_bypass,
  input wire logic stab_enabled,
  input wire logic powered_down,
  input wire logic reference_on,
  input wire logic data_out_oe,
  input wire logic data_capture_clock_oe,
  input wire logic overrange_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----------------
  // Power sequences
  // ----------------
  sequence s_pd_held;
    power_off_request [*5];
  endsequence
  sequence s_stby_held;
    (!power_off_request && pwr_mode_cfg == `DAC_PWR_STBY) [*5];
  endsequence
  AST_RESET_DEFAULTS: assert property ($fell(srst) |-> stab_enabled && stab_bypass && reference_on)
    else $error("reset defaults wrong");
  AST_PD_ENTER: assert property (s_pd_held |-> powered_down)
    else $error("power-down not entered");
  AST_PD_EXIT: assert property ($fell(power_off_request) && pwr_mode_cfg == `DAC_PWR_RUN |-> ##[1:4] !powered_down)
    else $error("power-down not left");
  AST_PD_TRISTATE: assert property (powered_down |-> !data_out_oe && !overrange_oe && !data_capture_clock_oe)
    else $error("driver on in power-down");
  AST_OEB_DATA: assert property (output_disable_pin |-> !data_out_oe && !overrange_oe)
    else $error("driver on with disable pin high");
  AST_STBY_REF: assert property (s_stby_held |-> reference_on && powered_down)
    else $error("standby state wrong");
  AST_PD_REF_OFF: assert property (s_pd_held |-> !reference_on)
    else $error("reference on in power-down");
  AST_SLOW_UNLOCK: assert property (in_clk_slow [*2] |-> !stab_locked)
    else $error("locked on slow clock");
  AST_UNLOCK_BYPASS: assert property (!stab_locked |-> stab_bypass)
    else $error("unlocked but not bypassed");
  AST_LOCK_USED: assert property (stab_locked && stab_enabled |-> !stab_bypass)
    else $error("locked but bypassed");
endmodule // dac_ctrl_props
bind dac_clock_output_ctrl dac_ctrl_props u_dac_ctrl_props (.core_clk, .srst, .in_clk_slow,
  .power_off_request, .pwr_mode_cfg, .output_disable_pin, .stab_locked, .stab_bypass,
  .stab_enabled, .powered_down, .reference_on, .data_out_oe, .data_capture_clock_oe,
  .overrange_oe);
`default_nettype wire

// [sim/dac_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module dac_capture_model (
  input wire logic data_capture_clock,
  input wire logic data_capture_clock_oe,
  input wire logic [`DAC_SAMPLE_W-1:0] data_out,
  input wire logic data_out_oe,
  output logic [`DAC_SAMPLE_W-1:0] word_hi,
  output logic [`DAC_SAMPLE_W-1:0] word_lo
);
  initial word_hi = 12'h000;
  initial word_lo = 12'h000;
  always @(posedge data_capture_clock) begin
    #2;
    if (data_out_oe && data_capture_clock_oe) word_hi = data_out;
  end
  always @(negedge data_capture_clock) begin
    #2;
    if (data_out_oe && data_capture_clock_oe) word_lo = data_out;
  end
endmodule // dac_capture_model
`default_nettype wire

// [sim/dac_clock_output_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module dac_clock_output_ctrl_bench;
  logic core_clk = 1'b0, srst = 1'b1, sync_pin = 1'b0, sync_ctl_wr = 1'b0;
  logic stab_cfg_wr = 1'b0, stab_cfg_en = 1'b1, in_clk_slow = 1'b0, freq_change = 1'b0;
  logic raw_in_clk_level = 1'b0, power_off_request = 1'b0, output_disable_pin = 1'b0;
  logic [2:0] div_ratio_m1 = 3'h0;
  logic [7:0] sync_ctl_data = 8'h00, out_ctl_a = 8'h00, out_ctl_b = 8'h00;
  logic [1:0] pwr_mode_cfg = `DAC_PWR_RUN, fmt_cfg = `DAC_FMT_RST;
  logic [12:0] ain_a = 13'h0000, ain_b = 13'h0000;
  logic [12:0] corner [5] = '{13'h1000, 13'h1800, 13'h0000, 13'h07FF, 13'h0800};
  wire conv_strobe, int_clk, stab_locked, stab_bypass, stab_enabled, powered_down;
  wire reference_on, data_out_oe, data_capture_clock, data_capture_clock_oe;
  wire overrange, overrange_oe;
  wire [11:0] data_out, word_hi, word_lo;
  int failures = 0, samples_checked = 0, cycles = 0, seed = 64, d0, d1, d2;
  dac_clock_output_ctrl u_dac_clock_output_ctrl (.core_clk, .srst, .div_ratio_m1, .sync_pin,
    .sync_ctl_wr, .sync_ctl_data, .stab_cfg_wr, .stab_cfg_en, .in_clk_slow, .freq_change,
    .raw_in_clk_level, .power_off_request, .pwr_mode_cfg, .output_disable_pin, .out_ctl_a,
    .out_ctl_b, .fmt_cfg, .ain_a, .ain_b, .conv_strobe, .int_clk, .stab_locked, .stab_bypass,
    .stab_enabled, .powered_down, .reference_on, .data_out, .data_out_oe, .data_capture_clock,
    .data_capture_clock_oe, .overrange, .overrange_oe);
  dac_capture_model u_dac_capture_model (.data_capture_clock, .data_capture_clock_oe,
    .data_out, .data_out_oe, .word_hi, .word_lo);
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) raw_in_clk_level <= ~raw_in_clk_level;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------
  // Helpers
  // ----------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic logic [12:0] enc(input logic [12:0] a, input logic [1:0] f);
    logic [11:0] t;
    t = (a[12] ^ a[11]) ? (a[12] ? `DAC_NEG_FS : `DAC_POS_FS) : a[11:0];
    if (f != `DAC_FMT_TWOS) t = t ^ 12'h800;
    if (f == `DAC_FMT_GRAY) t = t ^ (t >> 1);
    return {a[12] ^ a[11], t};
  endfunction
  task automatic sample(input logic [12:0] a, input logic [1:0] f);
    tick(1);
    ain_a = a;
    fmt_cfg = f;
    tick(14);
    check({overrange, data_out}, enc(a, f));
  endtask
  task automatic period(output int p);
    int n;
    n = 0;
    while (conv_strobe !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    p = 0;
    do begin
      tick(1);
      p++;
    end while (conv_strobe !== 1'b1 && p < 20);
  endtask
  task automatic phase(input int k, output int d);
    tick(k);
    sync_pin = 1'b1;
    tick(6);
    sync_pin = 1'b0;
    tick(4);
    d = 0;
    while (conv_strobe !== 1'b1 && d < 20) begin
      tick(1);
      d++;
    end
  endtask
  task automatic wr_sync(input logic [7:0] v);
    tick(1);
    sync_ctl_data = v;
    sync_ctl_wr = 1'b1;
    tick(1);
    sync_ctl_wr = 1'b0;
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    tick(16);
    srst = 1'b0;
    tick(1);
    check({stab_enabled, stab_bypass, reference_on}, 3'h7);
    freq_change = 1'b1;
    tick(1);
    freq_change = 1'b0;
    d0 = 0;
    while (stab_locked !== 1'b1 && d0 < 400) begin
      tick(1);
      d0++;
    end
    check(d0 >= 75 && d0 <= 250, 1'b1);
    check(stab_bypass, 1'b0);
    in_clk_slow = 1'b1;
    tick(4);
    check({stab_locked, stab_bypass}, 2'h1);
    check(int_clk, raw_in_clk_level);
    in_clk_slow = 1'b0;
    stab_cfg_en = 1'b0;
    stab_cfg_wr = 1'b1;
    tick(1);
    stab_cfg_wr = 1'b0;
    tick(80);
    check({stab_enabled, stab_locked, stab_bypass}, 3'h1);
    stab_cfg_en = 1'b1;
    stab_cfg_wr = 1'b1;
    tick(1);
    stab_cfg_wr = 1'b0;
    $display("test stabilizer done at %0t", $time);
    foreach (corner[i]) for (int f = 0; f < 3; f++) sample(corner[i], f[1:0]);
    repeat (20) begin
      d1 = $random(seed);
      sample(d1[12:0], d1[13] ? `DAC_FMT_GRAY : `DAC_FMT_OFFBIN);
    end
    sample(13'h0000, `DAC_FMT_TWOS);
    ain_a = 13'h0800;
    d0 = 0;
    while ({overrange, data_out} !== 13'h17FF && d0 < 40) begin
      tick(1);
      d0++;
    end
    check(d0 == `DAC_LATENCY + 1, 1'b1);
    $display("test data path done at %0t", $time);
    for (int m = 0; m < 8; m++) begin
      div_ratio_m1 = m[2:0];
      tick(20);
      period(d0);
      check(d0 == m + 1, 1'b1);
      d1 = 0;
      repeat (m + 1) begin
        tick(1);
        d1 += int_clk;
      end
      check(d1, m / 2 + 1);
    end
    wr_sync(8'h02);
    phase(0, d0);
    phase(2, d1);
    phase(5, d2);
    check(d1 == d0 && d2 == d0, 1'b1);
    wr_sync(8'h06);
    phase(5, d1);
    check(d1 == d0, 1'b1);
    phase(2, d1);
    phase(5, d2);
    check(d1 != d2, 1'b1);
    wr_sync(8'h00);
    phase(2, d1);
    phase(5, d2);
    check(d1 != d2, 1'b1);
    $display("test divider done at %0t", $time);
    div_ratio_m1 = 3'h1;
    ain_a = 13'h0123;
    ain_b = 13'h0456;
    fmt_cfg = `DAC_FMT_TWOS;
    out_ctl_b = 8'h10;
    tick(40);
    check({word_hi, word_lo}, {12'h123, 12'h123});
    out_ctl_b = 8'h00;
    tick(40);
    check({word_hi, word_lo}, {12'h123, 12'h456});
    out_ctl_a = 8'h10;
    out_ctl_b = 8'h10;
    tick(4);
    check(data_out_oe, 1'b0);
    out_ctl_a = 8'h00;
    out_ctl_b = 8'h00;
    output_disable_pin = 1'b1;
    tick(4);
    check({data_out_oe, overrange_oe}, 2'h0);
    output_disable_pin = 1'b0;
    tick(4);
    check(data_out_oe, 1'b1);
    power_off_request = 1'b1;
    tick(6);
    check({powered_down, reference_on, data_out_oe, data_capture_clock_oe}, 4'h8);
    power_off_request = 1'b0;
    tick(6);
    check(powered_down, 1'b0);
    pwr_mode_cfg = `DAC_PWR_STBY;
    tick(6);
    check({powered_down, reference_on}, 2'h3);
    pwr_mode_cfg = `DAC_PWR_DOWN;
    tick(6);
    check({powered_down, reference_on}, 2'h2);
    pwr_mode_cfg = `DAC_PWR_RUN;
    tick(6);
    $display("test power done at %0t", $time);
    finish_test();
  end
endmodule // dac_clock_output_ctrl_bench
`default_nettype wire
